// ### asp_pkg.sv
// Contract
// - power-on copies fuse values into configuration flops
// - host may overwrite configuration over serial port
// - any reset drops host writes, reloads fuses
// - host should configure within 120 us window
// - writes after the window are still accepted
// - clock reference defaults to internal oscillator
// - configured external clock on pin C feeds PLL
// - external clock only with pulse-width or short-code
// - one secondary interface drives pin A; pins B, C only with incremental or Hall
// - fuse reads 0 grounded, 1 when burned
// - angle 15 bits, sine and cosine 16 bits
// - preconfigured parts run secondary interface from fuses
package asp_pkg;
  // ==========================================================
  // serial frame: [23] read, [22:16] address, [15:0] data
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 8;
  localparam logic [4:0] FRAME_BITS_5 = 5'h18;
  localparam logic [4:0] HDR_BITS_5 = 5'h08;
  // ==========================================================
  // device register indices
  localparam logic [6:0] REG_CFG = 7'h00;
  localparam logic [6:0] REG_CAL_OFS = 7'h01;
  localparam logic [6:0] REG_CAL_AMP = 7'h02;
  localparam logic [6:0] REG_ANGLE = 7'h03;
  localparam logic [6:0] REG_SIN = 7'h04;
  localparam logic [6:0] REG_COS = 7'h05;
  localparam logic [6:0] REG_STAT = 7'h06;
  // configuration word fields
  localparam int CFG_IFACE_LSB = 0;
  localparam int CFG_EXT_CLK_BIT = 2;
  // fuse vector layout: cfg, offset, amplitude
  localparam int FUSE_BITS = 48;
  localparam int FUSE_CFG_LSB = 0;
  localparam int FUSE_OFS_LSB = 16;
  localparam int FUSE_AMP_LSB = 32;
  // secondary interface choices
  typedef enum logic [1:0] {
    IFACE_PWM = 2'b00,
    IFACE_INCR = 2'b01,
    IFACE_HALL = 2'b10,
    IFACE_SPC = 2'b11
  } asp_iface_t;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int EARLY_WINDOW_US = 120;
  localparam int EARLY_WINDOW_CYC = EARLY_WINDOW_US * CLK_MHZ;
  localparam int SCK_HALF_CYC = 8;
  localparam int EXT_CLK_HALF_CYC = 4;
  // ==========================================================
  // host controller AHB-Lite register byte offsets
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_WDATA = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h08;
  localparam logic [7:0] HOST_CTRL = 8'h0C;
endpackage

// ### asp_link_if.sv
`timescale 1ns/10ps
// ==========================================================
// serial port plus interface pins A, B, C
interface asp_link_if;
  logic sclk;
  logic csn;
  logic dio_h;
  logic dio_h_oe;
  logic dio_d;
  logic dio_d_oe;
  logic dio;
  logic pc_h;
  logic pc_h_oe;
  logic pc_d;
  logic pc_d_oe;
  logic pc;
  logic pa;
  logic pa_oe;
  logic pb;
  logic pb_oe;
  // resolved wire levels: data pulled up, pin C pulled down
  assign dio = dio_d_oe ? dio_d : (dio_h_oe ? dio_h : 1'b1);
  assign pc = pc_d_oe ? pc_d : (pc_h_oe ? pc_h : 1'b0);
  modport dev (input sclk, input csn, input dio, input pc,
    output dio_d, output dio_d_oe, output pc_d, output pc_d_oe,
    output pa, output pa_oe, output pb, output pb_oe);
  modport host (output sclk, output csn, output dio_h, output dio_h_oe,
    output pc_h, output pc_h_oe, input dio, input pc, input pa, input pa_oe,
    input pb, input pb_oe);
endinterface

// ### asp_device.sv
`timescale 1ns/10ps
// ==========================================================
// sensor side: configuration flops, serial slave, clock select
module asp_device (
  input wire logic mclk,
  input wire logic rst_n,
  asp_link_if.dev link,
  input wire logic [asp_pkg::FUSE_BITS-1:0] fuse_bits,
  input wire logic int_osc,
  input wire logic [14:0] angle_in,
  input wire logic [15:0] sin_in,
  input wire logic [15:0] cos_in,
  input wire logic sec_a,
  input wire logic sec_b,
  input wire logic sec_c,
  output logic [1:0] iface_sel,
  output logic [15:0] cal_ofs,
  output logic [15:0] cal_amp,
  output logic pll_ref_ext,
  output logic pll_ref_clk,
  output logic bist_start
);
  // ==========================================================
  // synchronisers for pins
  logic [1:0] sclk_s;
  logic [1:0] csn_s;
  logic [1:0] dio_s;
  logic [1:0] pc_s;
  logic [1:0] osc_s;
  logic sclk_d;

  // two flops per outside input
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclk_s <= 2'b00;
      csn_s <= 2'b11;
      dio_s <= 2'b11;
      pc_s <= 2'b00;
      osc_s <= 2'b00;
      sclk_d <= 1'b0;
    end else begin
      sclk_s <= {sclk_s[0], link.sclk};
      csn_s <= {csn_s[0], link.csn};
      dio_s <= {dio_s[0], link.dio};
      pc_s <= {pc_s[0], link.pc};
      osc_s <= {osc_s[0], int_osc};
      sclk_d <= sclk_s[1];
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic sel;
  assign sck_rise = sclk_s[1] & ~sclk_d;
  assign sck_fall = ~sclk_s[1] & sclk_d;
  assign sel = ~csn_s[1];

  // ==========================================================
  // configuration flops
  logic [15:0] cfg_r;
  logic [15:0] ofs_r;
  logic [15:0] amp_r;
  logic wr_stb;
  logic [6:0] wr_addr;
  logic [15:0] wr_data;

  // reset loads fuse image, serial writes overwrite it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_r <= fuse_bits[asp_pkg::FUSE_CFG_LSB +: 16];
      ofs_r <= fuse_bits[asp_pkg::FUSE_OFS_LSB +: 16];
      amp_r <= fuse_bits[asp_pkg::FUSE_AMP_LSB +: 16];
    end else if (wr_stb) begin
      // accepted at any time after reset
      case (wr_addr)
        asp_pkg::REG_CFG: cfg_r <= wr_data;
        asp_pkg::REG_CAL_OFS: ofs_r <= wr_data;
        asp_pkg::REG_CAL_AMP: amp_r <= wr_data;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // clock reference and interface selection
  asp_pkg::asp_iface_t iface;
  logic ext_ok;
  assign iface = asp_pkg::asp_iface_t'(cfg_r[asp_pkg::CFG_IFACE_LSB +: 2]);
  // external clock allowed only with pulse-width or short code
  assign ext_ok = cfg_r[asp_pkg::CFG_EXT_CLK_BIT] &&
    (iface == asp_pkg::IFACE_PWM || iface == asp_pkg::IFACE_SPC);

  // reference select, registered
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pll_ref_ext <= 1'b0;
      pll_ref_clk <= 1'b0;
    end else begin
      pll_ref_ext <= ext_ok;
      pll_ref_clk <= ext_ok ? pc_s[1] : osc_s[1];
    end
  end

  // secondary pin drive for the one chosen interface
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.pa <= 1'b0;
      link.pa_oe <= 1'b0;
      link.pb <= 1'b0;
      link.pb_oe <= 1'b0;
      link.pc_d <= 1'b0;
      link.pc_d_oe <= 1'b0;
      iface_sel <= 2'b00;
      cal_ofs <= 16'h0000;
      cal_amp <= 16'h0000;
    end else begin
      iface_sel <= iface;
      cal_ofs <= ofs_r;
      cal_amp <= amp_r;
      link.pa <= sec_a;
      link.pa_oe <= 1'b1;
      link.pb <= sec_b;
      link.pc_d <= sec_c;
      case (iface)
        asp_pkg::IFACE_INCR, asp_pkg::IFACE_HALL: begin
          link.pb_oe <= 1'b1;
          link.pc_d_oe <= 1'b1;
        end
        default: begin
          // pin C stays an input for the external clock
          link.pb_oe <= 1'b0;
          link.pc_d_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // self-test start after the early configuration window
  logic [15:0] win_cnt_r;
  logic win_done_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      win_cnt_r <= 16'h0000;
      win_done_r <= 1'b0;
      bist_start <= 1'b0;
    end else begin
      bist_start <= 1'b0;
      if (!win_done_r) begin
        if (win_cnt_r == 16'(asp_pkg::EARLY_WINDOW_CYC - 1)) begin
          win_done_r <= 1'b1;
          bist_start <= 1'b1;
        end else begin
          win_cnt_r <= win_cnt_r + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // serial slave: sample on rising, drive on falling
  logic [4:0] bit_cnt_r;
  logic [22:0] sh_in_r;
  logic [15:0] sh_out_r;
  logic rd_r;
  logic [15:0] rdata;
  logic [6:0] rd_addr;
  assign rd_addr = sh_in_r[6:0];

  // register read mux
  always_comb begin
    case (rd_addr)
      asp_pkg::REG_CFG: rdata = cfg_r;
      asp_pkg::REG_CAL_OFS: rdata = ofs_r;
      asp_pkg::REG_CAL_AMP: rdata = amp_r;
      asp_pkg::REG_ANGLE: rdata = {1'b0, angle_in};
      asp_pkg::REG_SIN: rdata = sin_in;
      asp_pkg::REG_COS: rdata = cos_in;
      asp_pkg::REG_STAT: rdata = {13'h0000, win_done_r, ext_ok, 1'b0};
      default: rdata = 16'h0000;
    endcase
  end

  // receive shifter and write strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bit_cnt_r <= 5'h00;
      sh_in_r <= 23'h00_0000;
      rd_r <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      if (!sel) begin
        bit_cnt_r <= 5'h00;
        rd_r <= 1'b0;
      end else if (sck_rise && bit_cnt_r != asp_pkg::FRAME_BITS_5) begin
        sh_in_r <= {sh_in_r[21:0], dio_s[1]};
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == asp_pkg::HDR_BITS_5 - 5'h01) begin
          rd_r <= sh_in_r[6];
        end
        if (bit_cnt_r == asp_pkg::FRAME_BITS_5 - 5'h01 && !rd_r) begin
          wr_stb <= 1'b1;
          wr_addr <= sh_in_r[21:15];
          wr_data <= {sh_in_r[14:0], dio_s[1]};
        end
      end
    end
  end

  // transmit shifter for reads
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sh_out_r <= 16'h0000;
      link.dio_d <= 1'b1;
      link.dio_d_oe <= 1'b0;
    end else if (!sel || bit_cnt_r == asp_pkg::FRAME_BITS_5) begin
      link.dio_d_oe <= 1'b0;
    end else if (sck_rise && bit_cnt_r == asp_pkg::HDR_BITS_5 - 5'h01) begin
      sh_out_r <= 16'h0000;
    end else if (rd_r && bit_cnt_r == asp_pkg::HDR_BITS_5 && sck_fall && !link.dio_d_oe) begin
      link.dio_d <= rdata[15];
      link.dio_d_oe <= 1'b1;
      sh_out_r <= {rdata[14:0], 1'b0};
    end else if (rd_r && sck_fall && link.dio_d_oe) begin
      link.dio_d <= sh_out_r[15];
      sh_out_r <= {sh_out_r[14:0], 1'b0};
    end
  end
endmodule

// ### asp_host.sv
`timescale 1ns/10ps
// ==========================================================
// host controller: AHB-Lite registers, serial master
module asp_host (
  input wire logic mclk,
  input wire logic rst_n,
  asp_link_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b10
  } asp_hst_t;

  logic [1:0] din_s;
  logic [7:0] cmd_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic ext_en_r;
  logic done_r;
  logic early_r;
  logic go;
  logic busy;
  logic dph_wr_r;
  logic [7:0] dph_addr_r;
  asp_hst_t st_r;

  // ==========================================================
  // bus slave: zero wait, OKAY always
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph_wr_r <= hsel && htrans[1] && hready && hwrite;
      dph_addr_r <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[7:0])
          asp_pkg::HOST_CMD: hrdata <= {24'h00_0000, cmd_r};
          asp_pkg::HOST_WDATA: hrdata <= {16'h0000, wdata_r};
          asp_pkg::HOST_STATUS: hrdata <= {rdata_r, 13'h0000, early_r, done_r, busy};
          asp_pkg::HOST_CTRL: hrdata <= {31'h0000_0000, ext_en_r};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign busy = (st_r != ST_IDLE);
  assign go = dph_wr_r && dph_addr_r == asp_pkg::HOST_CMD && !busy;

  // software registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;
      wdata_r <= 16'h0000;
      ext_en_r <= 1'b0;
    end else if (dph_wr_r) begin
      case (dph_addr_r)
        asp_pkg::HOST_CMD: if (!busy) cmd_r <= hwdata[7:0];
        asp_pkg::HOST_WDATA: wdata_r <= hwdata[15:0];
        asp_pkg::HOST_CTRL: ext_en_r <= hwdata[0];
        default: ;
      endcase
    end
  end

  // early configuration window flag
  logic [15:0] win_cnt_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      win_cnt_r <= 16'h0000;
      early_r <= 1'b1;
    end else if (early_r) begin
      if (win_cnt_r == 16'(asp_pkg::EARLY_WINDOW_CYC - 1)) begin
        early_r <= 1'b0;
      end else begin
        win_cnt_r <= win_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // external reference clock on pin C
  logic [2:0] ext_cnt_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_cnt_r <= 3'h0;
      link.pc_h <= 1'b0;
      link.pc_h_oe <= 1'b0;
    end else begin
      link.pc_h_oe <= ext_en_r;
      if (ext_cnt_r == 3'(asp_pkg::EXT_CLK_HALF_CYC - 1)) begin
        ext_cnt_r <= 3'h0;
        link.pc_h <= ~link.pc_h;
      end else begin
        ext_cnt_r <= ext_cnt_r + 3'h1;
      end
    end
  end

  // ==========================================================
  // serial master
  logic [3:0] ph_cnt_r;
  logic [4:0] bits_r;
  logic [23:0] sh_r;
  logic half_end;
  assign half_end = (ph_cnt_r == 4'(asp_pkg::SCK_HALF_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      din_s <= 2'b11;
    end else begin
      din_s <= {din_s[0], link.dio};
    end
  end

  // frame sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      ph_cnt_r <= 4'h0;
      bits_r <= 5'h00;
      sh_r <= 24'h00_0000;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
      link.sclk <= 1'b0;
      link.csn <= 1'b1;
      link.dio_h <= 1'b1;
      link.dio_h_oe <= 1'b0;
    end else begin
      ph_cnt_r <= half_end ? 4'h0 : ph_cnt_r + 4'h1;
      case (st_r)
        ST_IDLE: begin
          ph_cnt_r <= 4'h0;
          if (go) begin
            st_r <= ST_SHIFT;
            done_r <= 1'b0;
            bits_r <= 5'h00;
            sh_r <= {hwdata[7:0], wdata_r};
            link.csn <= 1'b0;
            link.dio_h <= hwdata[7];
            link.dio_h_oe <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (half_end && !link.sclk) begin
            link.sclk <= 1'b1;
            bits_r <= bits_r + 5'h01;
            rdata_r <= {rdata_r[14:0], din_s[1]};
          end else if (half_end) begin
            link.sclk <= 1'b0;
            sh_r <= {sh_r[22:0], 1'b0};
            link.dio_h <= sh_r[22];
            if (bits_r == asp_pkg::HDR_BITS_5 && cmd_r[7]) begin  // hand data line over for read reply
              link.dio_h_oe <= 1'b0;
            end
            if (bits_r == asp_pkg::FRAME_BITS_5) begin
              st_r <= ST_GAP;
              link.dio_h_oe <= 1'b0;
            end
          end
        end
        ST_GAP: begin
          link.csn <= 1'b1;
          if (half_end) begin
            st_r <= ST_IDLE;
            done_r <= 1'b1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ### asp_link_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// link checks: serial framing, data and pin ownership
module asp_link_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csn,
  input wire logic dio_h_oe,
  input wire logic dio_d_oe,
  input wire logic pc,
  input wire logic pc_h_oe,
  input wire logic pc_d_oe,
  input wire logic pa_oe
);
  logic sclk_q_r;
  logic [4:0] rise_cnt_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // serial clock rises counted within one selection
  always_ff @(posedge mclk) begin
    sclk_q_r <= sclk;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || csn) begin
      rise_cnt_r <= 5'h00;
    end else if (sclk && !sclk_q_r) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end
  // ==========================================================
  // half periods of serial clock and pin C clock
  sequence half_high_s;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence half_low_s;
    !sclk [*8] ##1 sclk;
  endsequence
  sequence ext_half_s;
    (pc || !pc_h_oe) [*4] ##1 !pc;
  endsequence
  // ==========================================================
  // framing, ownership and enables
  frame_start_a: assert property ($fell(csn) |-> half_low_s)
    else $error("first clock rise not 8 cycles after select");
  sclk_high_a: assert property ($rose(sclk) |-> half_high_s)
    else $error("serial clock high phase wrong");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase short");
  idle_clock_a: assert property (csn && $past(csn) |-> !sclk)
    else $error("serial clock moves while deselected");
  frame_len_a: assert property ($rose(csn) |-> rise_cnt_r == asp_pkg::FRAME_BITS_5)
    else $error("frame not 24 clocks");
  data_owner_a: assert property (dio_d_oe |-> !dio_h_oe)
    else $error("both ends drive data");
  dev_drive_sel_a: assert property ($rose(dio_d_oe) |-> !csn)
    else $error("device drives data while deselected");
  pin_c_owner_a: assert property (pc_h_oe |-> !pc_d_oe)
    else $error("both ends drive pin C");
  pin_a_on_a: assert property ($past(rst_n) |-> pa_oe)
    else $error("pin A not driven");
  ext_period_a: assert property (pc_h_oe && $past(pc_h_oe) && !pc_d_oe && $rose(pc) |-> ext_half_s)
    else $error("external clock half period not 4 cycles");
endmodule

// ### tb.sv
`timescale 1ns/10ps
// ==========================================================
// bench: host and device joined by the link, host driven over AHB-Lite
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [47:0] fuse_bits = 48'h0000_0000_0000;
  logic int_osc = 1'b0;
  logic [14:0] angle_in = 15'h0000;
  logic [15:0] sin_in = 16'h0000;
  logic [15:0] cos_in = 16'h0000;
  logic [2:0] sec = 3'h0;
  logic [1:0] iface_sel;
  logic [15:0] cal_ofs;
  logic [15:0] cal_amp;
  logic pll_ref_ext;
  logic bist_start;
  logic pll_ref_clk;
  logic hresp;
  logic [2:0] osc_h = 3'h0;
  logic [2:0] pc_hist = 3'h0;
  logic [38:0] pe;
  logic snap = 1'b0;
  logic dph_rd = 1'b0;
  logic [31:0] rd;
  logic [15:0] cfg_e;
  logic [15:0] ofs_e;
  logic [15:0] amp_e;
  logic [63:0] bus_q[$];
  logic [38:0] pin_q[$];
  asp_pkg::asp_iface_t ifl[4] = '{asp_pkg::IFACE_PWM, asp_pkg::IFACE_SPC, asp_pkg::IFACE_INCR, asp_pkg::IFACE_HALL};
  int err_count = 0;
  int n_tests = 0;
  int seed = 45;
  int bist_cnt = 0;
  asp_link_if link();
  asp_host asp_host_i (.mclk(mclk), .rst_n(rst_n), .link(link.host), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));
  asp_device asp_device_i (.mclk(mclk), .rst_n(rst_n), .link(link.dev), .fuse_bits(fuse_bits), .int_osc(int_osc),
    .angle_in(angle_in), .sin_in(sin_in), .cos_in(cos_in), .sec_a(sec[0]), .sec_b(sec[1]), .sec_c(sec[2]),
    .iface_sel(iface_sel), .cal_ofs(cal_ofs), .cal_amp(cal_amp), .pll_ref_ext(pll_ref_ext), .pll_ref_clk(pll_ref_clk),
    .bist_start(bist_start));
  asp_link_monitor asp_link_monitor_i (.mclk(mclk), .rst_n(rst_n), .sclk(link.sclk), .csn(link.csn),
    .dio_h_oe(link.dio_h_oe), .dio_d_oe(link.dio_d_oe), .pc(link.pc), .pc_h_oe(link.pc_h_oe),
    .pc_d_oe(link.pc_d_oe), .pa_oe(link.pa_oe));
  always #5 mclk = ~mclk;
  // oscillator and secondary-protocol levels
  always @(posedge mclk) begin
    int_osc <= ~int_osc;
    sec <= 3'($random(seed));
    // source levels as the device's two-flop sync will see them
    osc_h <= {osc_h[1:0], int_osc};
    pc_hist <= {pc_hist[1:0], link.pc};
  end
  // watcher: pops the oldest note whenever a result shows
  always @(posedge mclk) begin
    if (bist_start === 1'b1) begin
      bist_cnt++;
    end
    if (dph_rd && bus_q.size() > 0) begin
      chk_bus(bus_q.pop_front(), hrdata, hresp);
    end
    if (snap && pin_q.size() > 0) begin
      pe = pin_q.pop_front();
      chk_pins(pe, {2'(bist_cnt), link.pc_d_oe, link.pb_oe, pll_ref_ext, iface_sel, cal_ofs, cal_amp});
      chk_ref(pe[34] ? pc_hist[2] : osc_h[2], pll_ref_clk);
    end
    dph_rd <= hsel && htrans[1] && (hreadyout === 1'b1) && !hwrite;
  end
  task automatic chk_bus(input logic [63:0] n, input logic [31:0] got, input logic r);
    n_tests++;
    if (r !== 1'b0) begin
      err_count++;
      $display("[FAIL] bus response exp 0 got %b", r);
    end
    if (n[63:32] !== 32'h0000_0000) begin
      n_tests++;
      if ((got & n[63:32]) !== (n[31:0] & n[63:32])) begin
        err_count++;
        $display("[FAIL] bus read exp %h got %h", n[31:0], got);
      end
    end
  endtask
  task automatic chk_pins(input logic [38:0] e, input logic [38:0] got);
    n_tests++;
    if (got !== e) begin
      err_count++;
      $display("[FAIL] device pins exp %h got %h", e, got);
    end
  endtask
  task automatic chk_ref(input logic e, input logic got);
    n_tests++;
    if (got !== e) begin
      err_count++;
      $display("[FAIL] reference clock exp %b got %b", e, got);
    end
  endtask
  function automatic logic [38:0] exp_pins(input logic [15:0] c, input logic [15:0] o, input logic [15:0] a,
    input logic [1:0] b);
    logic sec3;
    sec3 = (c[1:0] == asp_pkg::IFACE_INCR) || (c[1:0] == asp_pkg::IFACE_HALL);
    return {b, sec3, sec3, c[2] && !sec3, c[1:0], o, a};
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic bail();
    err_count++;
    $display("[FAIL] wait timeout exp done got none");
    give_verdict();
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 200);
    if (hreadyout !== 1'b1) begin
      bail();
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic [31:0] e);
    if (!w) begin
      bus_q.push_back({m, e});
    end
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000, m, e);
  endtask
  // one serial frame, polled until done
  task automatic frame(input logic [7:0] cmd, input logic [15:0] d);
    int n;
    wr(asp_pkg::HOST_WDATA, {16'h0000, d});
    wr(asp_pkg::HOST_CMD, {24'h00_0000, cmd});
    n = 0;
    do begin
      rdc(asp_pkg::HOST_STATUS, 32'h0000_0000, 32'h0000_0000);
      n++;
    end while ((rd[0] !== 1'b0 || rd[1] !== 1'b1) && n < 500);
    if (rd[1] !== 1'b1) begin
      bail();
    end
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [31:0] m, input logic [31:0] e);
    frame({1'b1, a}, 16'h0000);
    rdc(asp_pkg::HOST_STATUS, m, e);
  endtask
  task automatic pins(input logic [15:0] c, input logic [15:0] o, input logic [15:0] a, input logic [1:0] b);
    pin_q.push_back(exp_pins(c, o, a, b));
    // let the reference path refill after a reset
    repeat (3) @(posedge mclk);
    snap <= 1'b1;
    @(posedge mclk);
    snap <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    fuse_bits <= 48'({$random(seed), $random(seed)});
    angle_in <= 15'($random(seed));
    sin_in <= 16'($random(seed));
    cos_in <= 16'($random(seed));
    repeat (6) @(posedge mclk);
    bist_cnt = 0;
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    pins(fuse_bits[15:0], fuse_bits[31:16], fuse_bits[47:32], 2'h0);
    rdc(asp_pkg::HOST_STATUS, 32'h0000_0004, 32'h0000_0004);
    rdc(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    ofs_e = fuse_bits[31:16];
    amp_e = fuse_bits[47:32];
    for (int i = 0; i < 4; i++) begin
      if (i == 2) begin
        wr(asp_pkg::HOST_CTRL, 32'h0000_0000);
      end
      cfg_e = {13'h0000, 1'b1, ifl[i]};
      frame({1'b0, asp_pkg::REG_CFG}, cfg_e);
      if (i == 0) begin
        wr(asp_pkg::HOST_CTRL, 32'h0000_0001);
      end
      pins(cfg_e, ofs_e, amp_e, 2'h0);
      rd_reg(asp_pkg::REG_STAT, 32'h0002_0000, {14'h0000, i < 2, 17'h0_0000});
    end
    ofs_e = 16'($random(seed));
    amp_e = 16'($random(seed));
    frame({1'b0, asp_pkg::REG_CAL_OFS}, ofs_e);
    frame({1'b0, asp_pkg::REG_CAL_AMP}, amp_e);
    frame({1'b0, asp_pkg::REG_ANGLE}, 16'hFFFF);
    pins(cfg_e, ofs_e, amp_e, 2'h0);
    rd_reg(asp_pkg::REG_ANGLE, 32'hFFFF_0000, {1'b0, angle_in, 16'h0000});
    rd_reg(asp_pkg::REG_SIN, 32'hFFFF_0000, {sin_in, 16'h0000});
    rd_reg(asp_pkg::REG_COS, 32'hFFFF_0000, {cos_in, 16'h0000});
    rd_reg(asp_pkg::REG_CAL_AMP, 32'hFFFF_0000, {amp_e, 16'h0000});
    repeat (asp_pkg::EARLY_WINDOW_CYC) @(posedge mclk);
    rdc(asp_pkg::HOST_STATUS, 32'h0000_0004, 32'h0000_0000);
    cfg_e = {14'h0000, asp_pkg::IFACE_SPC};
    frame({1'b0, asp_pkg::REG_CFG}, cfg_e);
    pins(cfg_e, ofs_e, amp_e, 2'h1);
    rd_reg(asp_pkg::REG_STAT, 32'h0004_0000, 32'h0004_0000);
    // reset in mid-frame drops host values
    wr(asp_pkg::HOST_WDATA, 32'h0000_1234);
    wr(asp_pkg::HOST_CMD, {25'h000_0000, asp_pkg::REG_CAL_OFS});
    repeat (50) @(posedge mclk);
    do_reset();
    pins(fuse_bits[15:0], fuse_bits[31:16], fuse_bits[47:32], 2'h0);
    rdc(asp_pkg::HOST_STATUS, 32'h0000_0004, 32'h0000_0004);
    @(posedge mclk);
    give_verdict();
  end
endmodule
